// File: rtl/cpu_register_file_with_flags.sv
// Architectural register file with processor flags.
// Assumes one core clock, an AHB-Lite master for software access and
// the core's execute and interrupt logic on the core-side ports.
//
// What this block does
// [RULE_01] Two banks of eight working registers
// [RULE_02] Data registers 16 bits, bytes of first two
// [RULE_03] Pair data 2:0 and 3:1 as 32 bits
// [RULE_04] Two 24-bit address registers
// [RULE_05] 24-bit static base register
// [RULE_06] 24-bit frame base register
// [RULE_07] User and interrupt stack pointers, one active
// [RULE_08] Software keeps stack pointers even
// [RULE_09] 24-bit interrupt vector table base
// [RULE_10] 24-bit program counter, next instruction
// [RULE_11] 16-bit flag register with all fields
// [RULE_12] Carry flag updated after carry instructions
// [RULE_13] Software keeps debug flag cleared
// [RULE_14] Zero flag set on zero result
// [RULE_15] Sign flag set on negative result
// [RULE_16] Bank flag routes working register accesses
// [RULE_17] Overflow flag follows arithmetic overflow
// [RULE_18] Enable flag gates maskable interrupts, cleared on ack
// [RULE_19] Stack flag zero selects interrupt stack
// [RULE_20] Interrupt accepted only above priority level
// [RULE_21] Synchronous updates, interrupt ack wins
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_defines.svh"

module cpu_register_file_with_flags
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core working register port
  input  wire logic        core_wr_en,
  input  wire logic [2:0]  core_wr_sel,
  input  wire logic [1:0]  core_wr_mode,
  input  wire logic [31:0] core_wr_data,
  input  wire logic [2:0]  core_rd_sel,
  output logic      [23:0] core_rd_data,
  output logic      [31:0] wide_data_pair_low,
  output logic      [31:0] wide_data_pair_high,
  // Stack pointer, program counter and flags
  input  wire logic        sp_wr_en,
  input  wire logic [23:0] sp_wr_data,
  output logic      [23:0] active_sp,
  input  wire logic        pc_load,
  input  wire logic [23:0] pc_next,
  output logic      [23:0] program_counter,
  output logic      [23:0] vector_table_base,
  input  wire logic        flg_wr_en,
  input  wire logic [15:0] flg_wr_data,
  output logic      [15:0] processor_flags,
  // ALU flag update
  input  wire logic        alu_upd_c,
  input  wire logic        alu_upd_zs,
  input  wire logic        alu_upd_o,
  input  wire logic [1:0]  alu_size,
  input  wire logic [31:0] alu_result,
  input  wire logic        alu_carry,
  input  wire logic        alu_ovfl,
  // Interrupt side
  input  wire logic        irq_req,
  input  wire logic        irq_maskable,
  input  wire logic [2:0]  irq_level,
  output logic             irq_accept,
  input  wire logic        irq_ack,
  input  wire logic        sw_int,
  input  wire logic [5:0]  sw_int_num
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  ////////////////////////////////////////////////////////////////////////

  logic [23:0] work_regs [0:15];  // Index is bank, then register
  logic [23:0] user_stack_pointer;      // Selected when stack flag is one
  logic [23:0] interrupt_stack_pointer; // Selected when stack flag is zero

  // Bus data phase state
  logic        dp_wr;       // Write data phase pending
  logic        dp_rd;       // Read data phase pending
  logic        rd_done;     // Read data captured, answer now
  logic [7:0]  dp_addr;     // Latched address

  // Flag fields read out of the flag register
  logic        bank_flag;
  logic        stack_flag;
  logic        ien_flag;
  logic [2:0]  processor_priority_level;

  assign bank_flag  = processor_flags[`FLG_BANK];
  assign stack_flag = processor_flags[`FLG_STACK];
  assign ien_flag   = processor_flags[`FLG_IEN];
  assign processor_priority_level =
    processor_flags[`FLG_IPL_HI:`FLG_IPL_LO];

  ////////////////////////////////////////////////////////////////////////
  // Functions
  ////////////////////////////////////////////////////////////////////////

  // Data registers hold 16 bits; the upper byte is forced to zero
  function automatic logic [23:0] fit(input logic [2:0] sel,
                                      input logic [23:0] val);
    if (sel < 3'd4)
      fit = {8'h00, val[15:0]};  // [RULE_02]
    else
      fit = val;                  // [RULE_04] [RULE_05] [RULE_06]
  endfunction

  // Zero test at the width of the operation
  function automatic logic res_zero(input logic [1:0] sz,
                                    input logic [31:0] r);
    case (cpu_regs_pkg::res_size_t'(sz))
      cpu_regs_pkg::SZ_BYTE: res_zero = (r[7:0] == 8'h00);
      cpu_regs_pkg::SZ_WORD: res_zero = (r[15:0] == 16'h0000);
      cpu_regs_pkg::SZ_ADDR: res_zero = (r[23:0] == 24'h00_0000);
      default:               res_zero = (r == 32'h0000_0000);
    endcase
  endfunction

  // Sign bit at the width of the operation
  function automatic logic res_sign(input logic [1:0] sz,
                                    input logic [31:0] r);
    case (cpu_regs_pkg::res_size_t'(sz))
      cpu_regs_pkg::SZ_BYTE: res_sign = r[7];
      cpu_regs_pkg::SZ_WORD: res_sign = r[15];
      cpu_regs_pkg::SZ_ADDR: res_sign = r[23];
      default:               res_sign = r[31];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase and answer
  ////////////////////////////////////////////////////////////////////////

  logic take;  // Valid transfer taken this cycle
  assign take = hsel && htrans[1] && hready;

  // Reads wait one cycle so a write just before is always visible
  assign hreadyout = !dp_rd || rd_done;
  assign hresp     = 1'b0;

  // Track the data phase of each transfer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      rd_done <= 1'b0;
      dp_addr <= 8'h00;
    end
    else
    begin
      if (hreadyout)
      begin
        dp_wr   <= take && hwrite;
        dp_rd   <= take && !hwrite;
        rd_done <= 1'b0;
        if (take)
          dp_addr <= haddr;
      end
      else
        rd_done <= 1'b1;  // Read data captured this edge
    end
  end

  // Bus write strobes per target
  logic        bw_work;
  logic [3:0]  bw_idx;
  logic        bw_usp;
  logic        bw_isp;
  logic        bw_vector_table_base;
  logic        bw_pc;
  logic        bw_flg;

  // Address decode of the pending write
  always_comb
  begin
    bw_work = 1'b0;
    bw_idx  = dp_addr[5:2];
    bw_usp  = 1'b0;
    bw_isp  = 1'b0;
    bw_vector_table_base = 1'b0;
    bw_pc   = 1'b0;
    bw_flg  = 1'b0;
    if (!dp_wr)
      bw_work = 1'b0;
    else if (dp_addr < `OFS_USER_SP)
      bw_work = 1'b1;
    else if (dp_addr == `OFS_USER_SP)
      bw_usp = 1'b1;
    else if (dp_addr == `OFS_INT_SP)
      bw_isp = 1'b1;
    else if (dp_addr == `OFS_VECT_BASE)
      bw_vector_table_base = 1'b1;
    else if (dp_addr == `OFS_PROG_CNT)
      bw_pc = 1'b1;
    else if (dp_addr == `OFS_FLAGS)
      bw_flg = 1'b1;
  end

  // Read mux; unmapped space reads zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (dp_addr < `OFS_USER_SP)
      rd_mux = {8'h00, work_regs[dp_addr[5:2]]};
    else if (dp_addr == `OFS_USER_SP)
      rd_mux = {8'h00, user_stack_pointer};
    else if (dp_addr == `OFS_INT_SP)
      rd_mux = {8'h00, interrupt_stack_pointer};
    else if (dp_addr == `OFS_VECT_BASE)
      rd_mux = {8'h00, vector_table_base};
    else if (dp_addr == `OFS_PROG_CNT)
      rd_mux = {8'h00, program_counter};
    else if (dp_addr == `OFS_FLAGS)
      rd_mux = {16'h0000, processor_flags};
    else if (dp_addr == `OFS_ACTIVE_SP)
      rd_mux = {8'h00, active_sp};
    else if (dp_addr == `OFS_PAIR_LOW)
      rd_mux = wide_data_pair_low;
    else if (dp_addr == `OFS_PAIR_HIGH)
      rd_mux = wide_data_pair_high;
  end

  // Capture read data in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (dp_rd && !rd_done)
      hrdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Working registers
  ////////////////////////////////////////////////////////////////////////

  logic [3:0] cw_idx;  // Core write target in the selected bank
  logic [3:0] cr_idx;  // Core read source in the selected bank
  assign cw_idx = {bank_flag, core_wr_sel};  // [RULE_16]
  assign cr_idx = {bank_flag, core_rd_sel};  // [RULE_16]

  // Bus writes first, core writes override in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 16; i++)
        work_regs[i] <= `REG_RESET;  // [RULE_01]
    end
    else
    begin
      if (bw_work)
        work_regs[bw_idx] <= fit(bw_idx[2:0], hwdata[23:0]);
      if (core_wr_en)
      begin
        case (cpu_regs_pkg::wr_mode_t'(core_wr_mode))
          cpu_regs_pkg::WR_LOW_BYTE:
            work_regs[cw_idx][7:0] <= core_wr_data[7:0];  // [RULE_02]
          cpu_regs_pkg::WR_HIGH_BYTE:
            work_regs[cw_idx][15:8] <= core_wr_data[7:0]; // [RULE_02]
          cpu_regs_pkg::WR_PAIR:
          begin
            // Select 0 or 1 names the low half; high half is two above
            work_regs[{bank_flag, 2'b00, core_wr_sel[0]}] <=
              {8'h00, core_wr_data[15:0]};  // [RULE_03]
            work_regs[{bank_flag, 2'b01, core_wr_sel[0]}] <=
              {8'h00, core_wr_data[31:16]}; // [RULE_03]
          end
          default:
            work_regs[cw_idx] <= fit(core_wr_sel, core_wr_data[23:0]);
        endcase
      end
    end
  end

  // Registered core read of the selected bank
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      core_rd_data <= `REG_RESET;
    else
      core_rd_data <= work_regs[cr_idx];  // [RULE_16]
  end

  // 32-bit views of the data pairs in the selected bank
  assign wide_data_pair_low  = {work_regs[{bank_flag, 3'd2}][15:0],
                                work_regs[{bank_flag, 3'd0}][15:0]};
                                // [RULE_03]
  assign wide_data_pair_high = {work_regs[{bank_flag, 3'd3}][15:0],
                                work_regs[{bank_flag, 3'd1}][15:0]};
                                // [RULE_03]

  ////////////////////////////////////////////////////////////////////////
  // Stack pointers, vector base, program counter
  ////////////////////////////////////////////////////////////////////////

  // Only the active pointer follows core pushes and pops
  assign active_sp = stack_flag ? user_stack_pointer
                                : interrupt_stack_pointer;  // [RULE_19]

  // Stack pointers; odd values are kept as written
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      user_stack_pointer      <= `REG_RESET;
      interrupt_stack_pointer <= `REG_RESET;
    end
    else
    begin
      if (bw_usp)
        user_stack_pointer <= hwdata[23:0];
      if (bw_isp)
        interrupt_stack_pointer <= hwdata[23:0];
      if (sp_wr_en && stack_flag)
        user_stack_pointer <= sp_wr_data;       // [RULE_07]
      if (sp_wr_en && !stack_flag)
        interrupt_stack_pointer <= sp_wr_data;  // [RULE_07]
    end
  end

  // Vector table base, written by software only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      vector_table_base <= `REG_RESET;
    else if (bw_vector_table_base)
      vector_table_base <= hwdata[23:0];  // [RULE_09]
  end

  // Program counter; the core's load beats a bus write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      program_counter <= `REG_RESET;
    else if (pc_load)
      program_counter <= pc_next;         // [RULE_10]
    else if (bw_pc)
      program_counter <= hwdata[23:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags and interrupt gate
  ////////////////////////////////////////////////////////////////////////

  // Maskable requests need the enable flag; all need a higher level
  assign irq_accept = irq_req && (ien_flag || !irq_maskable) &&
                      (irq_level > processor_priority_level);
                      // [RULE_18] [RULE_20]

  // Later assignments win: bus, core write, ALU, then acknowledge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      processor_flags <= `FLG_RESET;  // [RULE_11]
    else
    begin
      if (bw_flg)
        processor_flags <= hwdata[15:0] & `FLG_WMASK;  // [RULE_11]
      if (flg_wr_en)
        processor_flags <= flg_wr_data & `FLG_WMASK;
      // Debug flag is stored as written; software keeps it zero
      if (alu_upd_c)
        processor_flags[`FLG_CARRY] <= alu_carry;  // [RULE_12]
      if (alu_upd_zs)
      begin
        processor_flags[`FLG_ZERO] <=
          res_zero(alu_size, alu_result);         // [RULE_14]
        processor_flags[`FLG_SIGN] <=
          res_sign(alu_size, alu_result);         // [RULE_15]
      end
      if (alu_upd_o)
        processor_flags[`FLG_OVFL] <= alu_ovfl;   // [RULE_17]
      if (sw_int && (sw_int_num < `SW_INT_LIMIT))
        processor_flags[`FLG_STACK] <= 1'b0;      // [RULE_19]
      if (irq_ack)
      begin
        processor_flags[`FLG_IEN]   <= 1'b0;      // [RULE_18] [RULE_21]
        processor_flags[`FLG_STACK] <= 1'b0;      // [RULE_19] [RULE_21]
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/cpu_regs_defines.svh
// Register offsets, flag bit positions, reset values and widths.
// Assumes inclusion by bare name from the register file only.
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

// Bus byte offsets, working registers of bank 0 then bank 1
`define OFS_BANK0          8'h00
`define OFS_BANK1          8'h20
`define OFS_USER_SP        8'h40
`define OFS_INT_SP         8'h44
`define OFS_VECT_BASE      8'h48
`define OFS_PROG_CNT       8'h4C
`define OFS_FLAGS          8'h50
`define OFS_ACTIVE_SP      8'h54
`define OFS_PAIR_LOW       8'h58
`define OFS_PAIR_HIGH      8'h5C

// Flag bit positions
`define FLG_CARRY          0
`define FLG_DEBUG          1
`define FLG_ZERO           2
`define FLG_SIGN           3
`define FLG_BANK           4
`define FLG_OVFL           5
`define FLG_IEN            6
`define FLG_STACK          7
`define FLG_IPL_LO         12
`define FLG_IPL_HI         14

// Writable flag bits; reserved bits read zero
`define FLG_WMASK          16'h70FF

// Reset values
`define REG_RESET          24'h00_0000
`define FLG_RESET          16'h0000

// Software interrupt numbers below this clear the stack flag
`define SW_INT_LIMIT       6'h20

`endif

// File: rtl/cpu_regs_pkg.sv
// Types used by the register file for write shapes and result widths.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cpu_regs_pkg;
  // Working register write shapes
  typedef enum logic [1:0] {
    WR_FULL,
    WR_LOW_BYTE,
    WR_HIGH_BYTE,
    WR_PAIR
  } wr_mode_t;

  // ALU result widths for zero and sign
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_ADDR,
    SZ_LONG
  } res_size_t;
endpackage
`default_nettype wire

// File: sim/core_side_model.sv
// Model of the core's execute and interrupt logic driving the core ports.
// Assumes the bench calls its tasks; outputs move just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module core_side_model
(
  input  wire logic        hclk,
  output logic             core_wr_en,
  output logic [2:0]       core_wr_sel,
  output logic [1:0]       core_wr_mode,
  output logic [31:0]      core_wr_data,
  output logic [2:0]       core_rd_sel,
  output logic             sp_wr_en,
  output logic [23:0]      sp_wr_data,
  output logic             pc_load,
  output logic [23:0]      pc_next,
  output logic             flg_wr_en,
  output logic [15:0]      flg_wr_data,
  output logic             alu_upd_c,
  output logic             alu_upd_zs,
  output logic             alu_upd_o,
  output logic [1:0]       alu_size,
  output logic [31:0]      alu_result,
  output logic             alu_carry,
  output logic             alu_ovfl,
  output logic             irq_req,
  output logic             irq_maskable,
  output logic [2:0]       irq_level,
  output logic             irq_ack,
  output logic             sw_int,
  output logic [5:0]       sw_int_num
);
  // Everything quiet at time zero; read select stays on register 0
  initial
  begin
    {core_wr_en, sp_wr_en, pc_load, flg_wr_en, irq_ack, sw_int} = '0;
    {alu_upd_c, alu_upd_zs, alu_upd_o, alu_carry, alu_ovfl} = '0;
    {irq_req, irq_maskable, irq_level, sw_int_num, alu_size} = '0;
    {core_wr_sel, core_wr_mode, core_rd_sel} = '0;
    {core_wr_data, alu_result, sp_wr_data, pc_next, flg_wr_data} = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Drop every strobe; core and flag write data toggle so stale values never match
  task automatic fin();
    @(posedge hclk);
    {core_wr_en, sp_wr_en, pc_load, flg_wr_en, irq_ack, sw_int} <= '0;
    {alu_upd_c, alu_upd_zs, alu_upd_o} <= '0;
    core_wr_data <= ~core_wr_data;
    flg_wr_data <= ~flg_wr_data;
    @(negedge hclk);
  endtask
  // One working register write in the current bank
  task automatic wr(input logic [2:0] s, input logic [1:0] m,
                    input logic [31:0] d);
    @(posedge hclk);
    core_wr_en <= 1'b1;
    core_wr_sel <= s;
    core_wr_mode <= m;
    core_wr_data <= d;
    fin();
  endtask
  // Flag write, acknowledge and software interrupt in one cycle
  task automatic evt(input logic a, input logic s, input logic [5:0] n,
                     input logic fe, input logic [15:0] fv);
    @(posedge hclk);
    irq_ack <= a;
    sw_int <= s;
    sw_int_num <= n;
    flg_wr_en <= fe;
    flg_wr_data <= fv & 16'hFFFD; // Debug flag always written 0
    fin();
  endtask
  // Stack pointer write and program counter load
  task automatic sp_pc(input logic se, input logic [23:0] sv,
                       input logic pe, input logic [23:0] pv);
    @(posedge hclk);
    sp_wr_en <= se;
    sp_wr_data <= sv & 24'hFF_FFFE; // Even stack addresses only
    pc_load <= pe;
    pc_next <= pv;
    fin();
  endtask
  // ALU flag update; u holds carry, zero/sign and overflow strobes
  task automatic alu(input logic [2:0] u, input logic [1:0] sz,
                     input logic [31:0] res, input logic cy, input logic ov);
    @(posedge hclk);
    {alu_upd_c, alu_upd_zs, alu_upd_o} <= u;
    alu_size <= sz;
    alu_result <= res;
    alu_carry <= cy;
    alu_ovfl <= ov;
    fin();
  endtask
  // Interrupt request levels, held until changed
  task automatic req(input logic r, input logic m, input logic [2:0] l);
    @(posedge hclk);
    irq_req <= r;
    irq_maskable <= m;
    irq_level <= l;
    @(negedge hclk);
  endtask
endmodule
`default_nettype wire

// File: sim/cpu_regs_checker.sv
// Checker for the register file's core and interrupt ports.
// Assumes a bind onto the register file; one clock, reset low.
`timescale 1ns/1ps
`default_nettype none
module cpu_regs_checker
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [23:0] active_sp,
  input wire logic        sp_wr_en,
  input wire logic [23:0] sp_wr_data,
  input wire logic        pc_load,
  input wire logic [23:0] pc_next,
  input wire logic [23:0] program_counter,
  input wire logic        flg_wr_en,
  input wire logic [15:0] processor_flags,
  input wire logic        alu_upd_c,
  input wire logic        alu_upd_zs,
  input wire logic [1:0]  alu_size,
  input wire logic [31:0] alu_result,
  input wire logic        alu_carry,
  input wire logic        irq_req,
  input wire logic        irq_maskable,
  input wire logic [2:0]  irq_level,
  input wire logic        irq_accept,
  input wire logic        irq_ack,
  input wire logic        sw_int,
  input wire logic [5:0]  sw_int_num
);
  default clocking dclk @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  AST_ACCEPT:
    assert property (irq_accept == (irq_req && irq_level >
      processor_flags[14:12] && (processor_flags[6] || !irq_maskable)))
    else $error("accept does not follow enable and level");
  AST_ACK:
    assert property (irq_ack |=> !processor_flags[6] && !processor_flags[7])
    else $error("acknowledge left enable or stack flag set");
  AST_SWINT:
    assert property (sw_int && sw_int_num < 6'd32 |=> !processor_flags[7])
    else $error("low software interrupt kept user stack");
  AST_SP_WRITE:
    assert property (sp_wr_en && !irq_ack && !sw_int && !flg_wr_en
      |=> active_sp == $past(sp_wr_data))
    else $error("active stack pointer not written");
  AST_PC_LOAD:
    assert property (pc_load |=> program_counter == $past(pc_next))
    else $error("program counter not loaded");
  AST_CARRY:
    assert property (alu_upd_c |=> processor_flags[0] == $past(alu_carry))
    else $error("carry flag not updated");
  AST_ZS_WORD:
    assert property (alu_upd_zs && alu_size == 2'd1 |=>
      processor_flags[2] == ($past(alu_result[15:0]) == 16'h0000) &&
      processor_flags[3] == $past(alu_result[15]))
    else $error("zero or sign wrong for word result");
  AST_RESVD:
    assert property (processor_flags[15] == 1'b0 &&
      processor_flags[11:8] == 4'h0)
    else $error("reserved flag bits not zero");
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the register file with processor flags.
// Assumes the core-side model and checker are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        irq_accept, core_wr_en, sp_wr_en, pc_load, flg_wr_en;
  logic        alu_upd_c, alu_upd_zs, alu_upd_o, alu_carry, alu_ovfl;
  logic        irq_req, irq_maskable, irq_ack, sw_int;
  logic [1:0]  htrans, core_wr_mode, alu_size;
  logic [2:0]  hsize, core_wr_sel, core_rd_sel, irq_level;
  logic [5:0]  sw_int_num;
  logic [7:0]  haddr;
  logic [15:0] processor_flags, flg_wr_data;
  logic [23:0] core_rd_data, active_sp, program_counter, vector_table_base;
  logic [23:0] sp_wr_data, pc_next;
  logic [31:0] hwdata, hrdata, core_wr_data, alu_result, r, e;
  logic [31:0] wide_data_pair_low, wide_data_pair_high;
  int          fail_count, total_checks, i, m;
  assign hready = hreadyout; // Single slave on the bus
  cpu_register_file_with_flags dut (.*);
  core_side_model core (.*);
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Hang guard, far beyond the expected run
  initial
  begin
    #400_000;
    fail_count++;
    results();
  end
  task automatic results();
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Value seen just before the edge is what that edge samples
  task automatic wait_rdy();
    logic ok;
    do
    begin
      @(negedge hclk);
      ok = hready;
      r = hrdata;
      @(posedge hclk);
    end while (ok !== 1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    @(negedge hclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0000_0000);
    chk(r, x);
    chk(32'(hresp), 32'h0000_0000); // Response always OKAY
  endtask
  // Written pattern, cut to 16 bits for data registers, else 24
  function automatic logic [31:0] ev(input logic [7:0] a);
    logic [31:0] p;
    p = 32'h9AA5_5A81 ^ {24'h00_0000, a};
    if (a < 8'h40 && !a[4])
      return p & 32'h0000_FFFF;
    return p & 32'h00FF_FFFF;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic t_map();
    for (i = 0; i < 20; i++)
      bus(8'(i * 4), 1'b1, 32'h9AA5_5A81 ^ 32'(i * 4));
    for (i = 0; i < 20; i++)
      rd(8'(i * 4), ev(8'(i * 4)));
    bus(8'h58, 1'b1, 32'hFFFF_FFFF); // Read-only view, write dropped
    rd(8'h58, (ev(8'h08) << 16) | ev(8'h00));
    rd(8'h60, 32'h0000_0000);
    chk(32'(active_sp), ev(8'h44));
    chk(32'(vector_table_base), ev(8'h48));
    chk(32'(program_counter), ev(8'h4C));
  endtask
  // Bank 1 byte, full and pair writes; bank 0 left alone
  task automatic t_bank();
    core.evt(1'b0, 1'b0, 6'd0, 1'b1, 16'h0010);
    core.wr(3'd0, 2'd1, 32'h0000_00AB);
    core.wr(3'd1, 2'd2, 32'h0000_00CD);
    e = (ev(8'h20) & 32'h0000_FF00) | 32'h0000_00AB;
    rd(8'h20, e);
    rd(8'h24, (ev(8'h24) & 32'h0000_00FF) | 32'h0000_CD00);
    chk(32'(core_rd_data), e);
    core.wr(3'd1, 2'd3, 32'h5678_9ABC);
    core.wr(3'd2, 2'd0, 32'hFFFF_2345);
    rd(8'h5C, 32'h5678_9ABC);
    chk(wide_data_pair_low, 32'h2345_0000 | e);
    core.wr(3'd5, 2'd0, 32'hFF12_3456);
    rd(8'h34, 32'h0012_3456);
    core.evt(1'b0, 1'b0, 6'd0, 1'b1, 16'h0000);
    rd(8'h5C, (ev(8'h0C) << 16) | ev(8'h04));
  endtask
  task automatic t_alu();
    for (i = 0; i < 4; i++)
    begin
      m = (i == 3) ? 31 : 8 * i + 7;
      core.alu(3'b010, 2'(i), 32'h1 << m, 1'b0, 1'b0);
      chk(32'(processor_flags), 32'h0000_0008);
      core.alu(3'b010, 2'(i), 32'h2 << m, 1'b0, 1'b0);
      chk(32'(processor_flags), 32'h0000_0004);
    end
    core.alu(3'b101, 2'd0, 32'h0000_0000, 1'b1, 1'b1);
    chk(32'(processor_flags), 32'h0000_0025);
    core.alu(3'b101, 2'd0, 32'h0000_0000, 1'b0, 1'b0);
    chk(32'(processor_flags), 32'h0000_0004);
  endtask
  task automatic t_irq();
    core.evt(1'b0, 1'b0, 6'd0, 1'b1, 16'h3040);
    core.req(1'b1, 1'b1, 3'd4);
    chk(32'(irq_accept), 32'h0000_0001);
    core.req(1'b1, 1'b1, 3'd3);
    chk(32'(irq_accept), 32'h0000_0000);
    core.evt(1'b0, 1'b0, 6'd0, 1'b1, 16'h3000);
    core.req(1'b1, 1'b1, 3'd7);
    chk(32'(irq_accept), 32'h0000_0000);
    core.req(1'b1, 1'b0, 3'd7);
    chk(32'(irq_accept), 32'h0000_0001);
    core.req(1'b0, 1'b0, 3'd0);
  endtask
  task automatic t_stack();
    core.evt(1'b0, 1'b0, 6'd0, 1'b1, 16'h00C0);
    chk(32'(active_sp), ev(8'h40));
    core.sp_pc(1'b1, 24'h00_1235, 1'b1, 24'hAB_CDEF);
    chk(32'(active_sp), 32'h0000_1234);
    chk(32'(program_counter), 32'h00AB_CDEF);
    core.evt(1'b1, 1'b0, 6'd0, 1'b1, 16'h00C0);
    chk(32'(processor_flags), 32'h0000_0000);
    chk(32'(active_sp), ev(8'h44));
    rd(8'h40, 32'h0000_1234);
    core.evt(1'b0, 1'b1, 6'd32, 1'b1, 16'h0080);
    chk(32'(processor_flags), 32'h0000_0080);
    core.evt(1'b0, 1'b1, 6'd31, 1'b0, 16'h0000);
    chk(32'(processor_flags), 32'h0000_0000);
  endtask
  // Reset in mid-run brings every register back to zero
  task automatic t_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk(32'(program_counter), 32'h0000_0000);
    chk(32'(active_sp), 32'h0000_0000);
    chk(32'(core_rd_data), 32'h0000_0000);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h48, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hresetn, hsel, hwrite, fail_count, total_checks} = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 8'h00;
    hwdata = 32'h0000_0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk(32'(processor_flags), 32'h0000_0000);
    rd(8'h50, 32'h0000_0000);
    t_map();
    t_bank();
    t_alu();
    t_irq();
    t_stack();
    t_reset();
    results();
  end
endmodule
bind cpu_register_file_with_flags cpu_regs_checker watch (.*);
`default_nettype wire
